// ===== sppp_params.svh
/*
 holds offsets, reset values and widths of the shared pin port.
 assumes inclusion by bare name from the package and the modules.
*/
`ifndef SPPP_PARAMS_SVH
`define SPPP_PARAMS_SVH
// ==========================================================
// register byte offsets
`define SPPP_OFF_DIR 6'h00
`define SPPP_OFF_LAT 6'h04
`define SPPP_OFF_PIN 6'h08
`define SPPP_OFF_ODC 6'h0C
`define SPPP_OFF_A1L 6'h10
`define SPPP_OFF_A1H 6'h14
`define SPPP_OFF_A2L 6'h18
`define SPPP_OFF_A2H 6'h1C
// ==========================================================
// reset values and widths
`define SPPP_DIR_RST 16'hFFFF
`define SPPP_LAT_RST 16'h0000
`define SPPP_ODC_RST 16'h0000
`define SPPP_ACFG_RST 16'h0000
`define SPPP_WIDTH 16
`define SPPP_IMPL_MASK 16'hFFFF
`define SPPP_ANA_MASK 32'h0000FFFF
`endif

// ===== sppp_pkg.sv
/*
 holds the types shared by the port modules.
 assumes the params header is on the include path.
*/
`include "sppp_params.svh"
package sppp_pkg;
    // ==========================================================
    // types
    typedef logic [`SPPP_WIDTH-1:0] sppp_word_t;
    typedef enum logic [1:0]
    {
        SPPP_IDLE = 2'b00,
        SPPP_ACK = 2'b01
    } sppp_bus_st_t;
endpackage : sppp_pkg

// ===== sppp_pin_if.sv
/*
 holds the interface carrying per-pin owner controls to the pin mux.
 assumes the main module drives the port side.
*/
`timescale 1ns/1ps
interface sppp_pin_if
    import sppp_pkg::*;
();
    sppp_word_t port_out;
    sppp_word_t port_oe;
    sppp_word_t odc;
    sppp_word_t analog;
    sppp_word_t pad_out;
    sppp_word_t pad_oe;
    sppp_word_t periph_in;
    modport port_side (output port_out, port_oe, odc, analog,
        input pad_out, pad_oe, periph_in);
    modport mux_side (input port_out, port_oe, odc, analog,
        output pad_out, pad_oe, periph_in);
endinterface : sppp_pin_if

// ===== sppp_pin_mux.sv
/*
 holds the per-pin output multiplexers between peripheral and port.
 assumes peripheral enables and drive requests come from the same clock.
*/
`timescale 1ns/1ps
`include "sppp_params.svh"
module sppp_pin_mux
    import sppp_pkg::*;
(
    // peripheral side
    input wire logic [`SPPP_WIDTH-1:0] per_en_i,
    input wire logic [`SPPP_WIDTH-1:0] per_oe_i,
    input wire logic [`SPPP_WIDTH-1:0] per_out_i,
    // pad input
    input wire logic [`SPPP_WIDTH-1:0] pad_in_i,
    // port side
    sppp_pin_if.mux_side pif
);
    // ==========================================================
    // ownership
    sppp_word_t per_own;
    sppp_word_t dout;
    sppp_word_t doe;
    assign per_own = per_en_i & per_oe_i; // R1 R2
    assign dout = (per_own & per_out_i) | (~per_own & pif.port_out); // R3
    assign doe = (per_own & per_oe_i) | (~per_own & pif.port_oe); // R1 R2
    // open drain drives only low
    assign pif.pad_out = dout & ~pif.odc; // R9
    assign pif.pad_oe = doe & ~(pif.odc & dout) & ~pif.analog; // R9
    // peripheral sees pin only when port is not driving it
    assign pif.periph_in = pad_in_i & ~(~per_own & pif.port_oe); // R3
endmodule : sppp_pin_mux

// ===== sppp_sync.sv
/*
 holds a three stage input synchroniser with agreement filter.
 assumes asynchronous pin inputs.
*/
`timescale 1ns/1ps
module sppp_sync
#(
    parameter int W = 16
)
(
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // data
    input wire logic [W-1:0] d_i,
    output logic [W-1:0] q_o
);
    // ==========================================================
    // stages
    logic [W-1:0] s1_r;
    logic [W-1:0] s2_r;
    logic [W-1:0] s3_r;
    logic [W-1:0] q_r;
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            s1_r <= '0;
            s2_r <= '0;
            s3_r <= '0;
        end
        else
        begin
            s1_r <= d_i;
            s2_r <= s1_r;
            s3_r <= s2_r;
        end
    end
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            q_r <= '0;
        else
            q_r <= (s2_r & s3_r) | (q_r & (s2_r | s3_r));
    end
    assign q_o = q_r;
endmodule : sppp_sync

// ===== sppp_port.sv
/*
 holds the shared pin parallel port with its wishbone register slave.
 assumes a classic wishbone master on clk_i and pins on an outside pad.
*/
// Design decisions made here: the Wishbone slave port and the register offsets.
`timescale 1ns/1ps
`include "sppp_params.svh"
// Function
// R1 - enabled driving peripheral disables port driver, pin still readable
// R2 - enabled idle peripheral leaves pin to port latch and direction
// R3 - per-pin mux chooses owner; port output never loops into peripheral
// R4 - direction bit one means input, zero means output
// R5 - reset makes every pin an input
// R6 - latch reads return latch, writes update latch
// R7 - pin level reads return pins, writes go to latch
// R8 - unimplemented bits read zero in latch, direction, pin level
// R9 - open drain select makes pin open drain, else push-pull
// R10 - cleared analog config bit makes pin analog
// R11 - analog-capable pins reset to analog, config bits zero
// R12 - pin analog when cleared in either converter's config
// R13 - analog pins read zero in pin level
// R14 - software sets analog pins to input before converting
// R15 - software waits one cycle between port write and read; pin level reads here show a latch write only four clocks later
// R16 - all port registers sixteen bits, one bit per pin
module sppp_port
    import sppp_pkg::*;
#(
    parameter logic [15:0] IMPL_MASK = `SPPP_IMPL_MASK,
    parameter logic [31:0] ANA_MASK = `SPPP_ANA_MASK
)
(
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // wishbone slave
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [5:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    output logic err_o,
    // peripheral side
    input wire logic [15:0] per_en_i,
    input wire logic [15:0] per_oe_i,
    input wire logic [15:0] per_out_i,
    output logic [15:0] per_in_o,
    // pads
    input wire logic [15:0] pad_in_i,
    output logic [15:0] pad_out_o,
    output logic [15:0] pad_oe_o,
    output logic [15:0] pad_analog_o
);
    // ==========================================================
    // helpers
    function automatic sppp_word_t wmerge(input sppp_word_t old,
        input logic [31:0] d, input logic [3:0] s);
        sppp_word_t r;
        r = old;
        if (s[0])
            r[7:0] = d[7:0];
        if (s[1])
            r[15:8] = d[15:8];
        return r;
    endfunction : wmerge

    // ==========================================================
    // bus decode
    sppp_word_t dir_r;
    sppp_word_t lat_r;
    sppp_word_t odc_r;
    sppp_word_t a1l_r;
    sppp_word_t a1h_r;
    sppp_word_t a2l_r;
    sppp_word_t a2h_r;
    sppp_word_t pin_s;
    sppp_word_t analog;
    sppp_word_t pin_read;
    logic req;
    logic hit;
    logic wr;
    logic ack_r;
    logic err_r;
    logic [31:0] dat_r;
    logic [31:0] rd_nxt;
    sppp_pin_if pif();

    assign req = cyc_i & stb_i & ~ack_r & ~err_r;
    always_comb
    begin
        hit = 1'b1;
        rd_nxt = 32'h0000_0000;
        case (adr_i)
            `SPPP_OFF_DIR: rd_nxt[15:0] = dir_r & IMPL_MASK; // R8 R16
            `SPPP_OFF_LAT: rd_nxt[15:0] = lat_r & IMPL_MASK; // R6 R8
            `SPPP_OFF_PIN: rd_nxt[15:0] = pin_read; // R7
            `SPPP_OFF_ODC: rd_nxt[15:0] = odc_r & IMPL_MASK;
            `SPPP_OFF_A1L: rd_nxt[15:0] = a1l_r;
            `SPPP_OFF_A1H: rd_nxt[15:0] = a1h_r;
            `SPPP_OFF_A2L: rd_nxt[15:0] = a2l_r;
            `SPPP_OFF_A2H: rd_nxt[15:0] = a2h_r;
            default: hit = 1'b0;
        endcase
    end
    assign wr = req & we_i & hit;

    // ==========================================================
    // bus answer
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            ack_r <= 1'b0;
            err_r <= 1'b0;
            dat_r <= 32'h0000_0000;
        end
        else
        begin
            ack_r <= req & hit;
            err_r <= req & ~hit;
            if (req & hit & ~we_i)
                dat_r <= rd_nxt;
        end
    end
    assign ack_o = ack_r;
    assign err_o = err_r;
    assign dat_o = dat_r;

    // ==========================================================
    // direction
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            dir_r <= `SPPP_DIR_RST; // R5
        else if (wr && adr_i == `SPPP_OFF_DIR)
            dir_r <= wmerge(dir_r, dat_i, sel_i) & IMPL_MASK;
    end

    // ==========================================================
    // output latch
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            lat_r <= `SPPP_LAT_RST;
        else if (wr && (adr_i == `SPPP_OFF_LAT || adr_i == `SPPP_OFF_PIN))
            lat_r <= wmerge(lat_r, dat_i, sel_i) & IMPL_MASK; // R6 R7
    end

    // ==========================================================
    // open drain
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            odc_r <= `SPPP_ODC_RST;
        else if (wr && adr_i == `SPPP_OFF_ODC)
            odc_r <= wmerge(odc_r, dat_i, sel_i) & IMPL_MASK; // R9
    end

    // ==========================================================
    // analog configuration
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            a1l_r <= `SPPP_ACFG_RST; // R11
            a1h_r <= `SPPP_ACFG_RST;
            a2l_r <= `SPPP_ACFG_RST;
            a2h_r <= `SPPP_ACFG_RST;
        end
        else if (wr)
        begin
            if (adr_i == `SPPP_OFF_A1L)
                a1l_r <= wmerge(a1l_r, dat_i, sel_i); // R10
            if (adr_i == `SPPP_OFF_A1H)
                a1h_r <= wmerge(a1h_r, dat_i, sel_i);
            if (adr_i == `SPPP_OFF_A2L)
                a2l_r <= wmerge(a2l_r, dat_i, sel_i);
            if (adr_i == `SPPP_OFF_A2H)
                a2h_r <= wmerge(a2h_r, dat_i, sel_i);
        end
    end
    // low config covers pins 15:0, high config pins 31:16 (none here)
    assign analog = (~a1l_r | ~a2l_r) & ANA_MASK[15:0]; // R10 R12

    // ==========================================================
    // pins
    sppp_sync #(.W(16)) u_sync
    (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .d_i(pad_in_i),
        .q_o(pin_s)
    );
    assign pin_read = pin_s & ~analog & IMPL_MASK; // R8 R13

    assign pif.port_out = lat_r;
    assign pif.port_oe = ~dir_r & IMPL_MASK; // R4
    assign pif.odc = odc_r;
    assign pif.analog = analog;

    sppp_pin_mux u_mux
    (
        .per_en_i(per_en_i & IMPL_MASK),
        .per_oe_i(per_oe_i),
        .per_out_i(per_out_i),
        .pad_in_i(pin_s),
        .pif(pif.mux_side)
    );
    assign pad_out_o = pif.pad_out;
    assign pad_oe_o = pif.pad_oe; // R1 R2
    assign per_in_o = pif.periph_in; // R3
    assign pad_analog_o = analog;
endmodule : sppp_port

// ===== sppp_monitor.sv
/*
 checker of the port's bus answers and pin outputs.
 assumes a bind onto sppp_port from the testbench top.
*/
`timescale 1ns/1ps
module sppp_monitor
(
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // bus
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [5:0] adr_i,
    input wire logic [31:0] dat_o,
    input wire logic ack_o,
    input wire logic err_o,
    // pins
    input wire logic [15:0] per_en_i,
    input wire logic [15:0] per_oe_i,
    input wire logic [15:0] per_out_i,
    input wire logic [15:0] per_in_o,
    input wire logic [15:0] pad_out_o,
    input wire logic [15:0] pad_oe_o,
    input wire logic [15:0] pad_analog_o
);
    // ==========================================================
    // properties
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    wire take = cyc_i && stb_i && !ack_o && !err_o;
    wire [15:0] own = per_en_i & per_oe_i & ~pad_analog_o;
    wire [15:0] per = per_en_i & per_oe_i;
    property p_ack;
        take && !adr_i[5] && adr_i[1:0] == 2'h0 |=> ack_o && !err_o;
    endproperty
    a_ack: assert property (p_ack) else $error("no ack");
    property p_err;
        take && adr_i[5] |=> err_o && !ack_o;
    endproperty
    a_err: assert property (p_err) else $error("no err");
    property p_pulse;
        ack_o |=> !ack_o;
    endproperty
    a_pulse: assert property (p_pulse) else $error("ack long");
    property p_own;
        (pad_out_o & own) == (per_out_i & pad_oe_o & own) &&
            (pad_oe_o & own & ~per_out_i) == (own & ~per_out_i);
    endproperty
    a_own: assert property (p_own) else $error("owner wrong");
    property p_loop;
        (per_in_o & pad_oe_o & ~per) == 16'h0000;
    endproperty
    a_loop: assert property (p_loop) else $error("loop through");
    property p_ana;
        (pad_oe_o & pad_analog_o & ~per) == 16'h0000;
    endproperty
    a_ana: assert property (p_ana) else $error("analog driven");
    property p_rst;
        disable iff (1'b0) rst_i |=> (pad_oe_o & ~per) == 16'h0000;
    endproperty
    a_rst: assert property (p_rst) else $error("reset drives");
    property p_pin0;
        take && !we_i && adr_i == 6'h08 |=>
            (dat_o[15:0] & pad_analog_o) == 16'h0000;
    endproperty
    a_pin0: assert property (p_pin0) else $error("analog reads");
    property p_hi;
        ack_o |-> dat_o[31:16] == 16'h0000;
    endproperty
    a_hi: assert property (p_hi) else $error("high bits");
    c_own: cover property (own != 16'h0000);
    c_err: cover property (err_o);
    c_pin: cover property (take && !we_i && adr_i == 6'h08);
endmodule : sppp_monitor

// ===== sppp_pad_model.sv
/*
 outside pin circuit: pull-ups and an outside source.
 assumes pins the port drives are not driven by the outside source.
*/
`timescale 1ns/1ps
module sppp_pad_model
(
    // pads from the port
    input wire logic [15:0] pad_out_i,
    input wire logic [15:0] pad_oe_i,
    // outside source
    input wire logic [15:0] ext_en_i,
    input wire logic [15:0] ext_val_i,
    // pin levels
    output logic [15:0] pin_o
);
    // ==========================================================
    // released pins go to the outside source value where it is enabled, else to the pull-up level
    assign pin_o = (pad_oe_i & pad_out_i) |
        (~pad_oe_i & (~ext_en_i | ext_val_i));
endmodule : sppp_pad_model

// ===== sppp_port_tb_top.sv
/*
 testbench of the shared pin port over classic wishbone.
 assumes the pad model and the bound checker.
*/
`timescale 1ns/1ps
`include "sppp_params.svh"
module sppp_port_tb_top;
    // ==========================================================
    // signals
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic cyc_i = 1'b0;
    logic stb_i = 1'b0;
    logic we_i = 1'b0;
    logic [5:0] adr_i = 6'h00;
    logic [3:0] sel_i = 4'h0;
    logic [31:0] dat_i = 32'h0;
    logic [31:0] dat_o, rdat;
    logic ack_o, err_o, rerr;
    logic [15:0] per_en_i = 16'h0, per_oe_i = 16'h0, per_out_i = 16'h0;
    logic [15:0] per_in_o, pad_in_i, pad_out_o, pad_oe_o, pad_analog_o;
    logic [15:0] ext_en = 16'hFF00, ext_val = 16'h9200;
    int n_mismatch = 0;
    int checks_done = 0;
    int cnt = 0;
    sppp_port #(.IMPL_MASK(16'h7FFF)) DUT (.*);
    sppp_pad_model pads (.pad_out_i(pad_out_o), .pad_oe_i(pad_oe_o),
        .ext_en_i(ext_en), .ext_val_i(ext_val), .pin_o(pad_in_i));
    // ==========================================================
    // clock and timeout
    initial
    begin
        forever #4 clk_i = ~clk_i;
    end
    always @(posedge clk_i)
    begin
        cnt <= cnt + 1;
        if (cnt == 3000)
        begin
            n_mismatch++;
            end_sim();
        end
    end
    // ==========================================================
    // tasks
    task automatic end_sim();
        if (n_mismatch == 0 && checks_done > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : end_sim
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("ERROR %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task automatic bus(input logic w, input logic [5:0] a,
        input logic [31:0] d, input logic [3:0] s);
        @(posedge clk_i);
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i <= w;
        adr_i <= a;
        dat_i <= d;
        sel_i <= s;
        do @(posedge clk_i); while (ack_o !== 1'b1 && err_o !== 1'b1);
        rdat = dat_o;
        rerr = err_o;
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
    endtask : bus
    task automatic wr(input logic [5:0] a, input logic [31:0] d);
        bus(1'b1, a, d, 4'hF);
    endtask : wr
    task automatic rdc(input logic [5:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0, 4'hF);
        chk(rdat, exp);
    endtask : rdc
    // ==========================================================
    // sequence
    initial
    begin
        repeat (20) @(posedge clk_i);
        rst_i <= 1'b0;
        rdc(`SPPP_OFF_DIR, 32'h7FFF);
        rdc(`SPPP_OFF_LAT, 32'h0);
        rdc(`SPPP_OFF_ODC, 32'h0);
        rdc(`SPPP_OFF_A1L, 32'h0);
        rdc(`SPPP_OFF_PIN, 32'h0);
        @(negedge clk_i);
        chk(pad_analog_o & 16'h7FFF, 32'h7FFF);
        wr(`SPPP_OFF_A1L, 32'hFFFF);
        wr(`SPPP_OFF_A2L, 32'hFFFE);
        @(negedge clk_i);
        chk(pad_analog_o & 16'h7FFF, 32'h1);
        wr(`SPPP_OFF_A2L, 32'hFFFF);
        @(negedge clk_i);
        chk(pad_analog_o & 16'h7FFF, 32'h0);
        wr(`SPPP_OFF_LAT, 32'hA5C3);
        rdc(`SPPP_OFF_LAT, 32'h25C3);
        wr(`SPPP_OFF_DIR, 32'hFF00);
        @(negedge clk_i);
        chk(pad_oe_o & 16'h7FFF, 32'h00FF);
        chk(pad_out_o & 16'h00FF, 32'h00C3);
        repeat (6) @(posedge clk_i);
        rdc(`SPPP_OFF_PIN, 32'h12C3);
        bus(1'b1, `SPPP_OFF_PIN, 32'h3C5A, 4'h1);
        rdc(`SPPP_OFF_LAT, 32'h255A);
        wr(`SPPP_OFF_ODC, 32'h3);
        @(negedge clk_i);
        chk(pad_oe_o[1:0], 32'h1);
        chk(pad_out_o[1:0], 32'h0);
        wr(`SPPP_OFF_ODC, 32'h0);
        per_en_i <= 16'h3;
        per_oe_i <= 16'h1;
        per_out_i <= 16'h1;
        @(negedge clk_i);
        chk(pad_out_o[1:0], 32'h3);
        chk(per_in_o[1], 32'h0);
        repeat (6) @(posedge clk_i);
        rdc(`SPPP_OFF_PIN, 32'h125B);
        per_oe_i <= 16'h0;
        @(negedge clk_i);
        chk(pad_out_o[1:0], 32'h2);
        bus(1'b0, 6'h20, 32'h0, 4'hF);
        chk(rerr, 32'h1);
        wr(`SPPP_OFF_A1H, 32'h1234ABCD);
        rdc(`SPPP_OFF_A1H, 32'h0000ABCD);
        rdc(`SPPP_OFF_A2H, 32'h0);
        rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        rdc(`SPPP_OFF_DIR, 32'h7FFF);
        rdc(`SPPP_OFF_LAT, 32'h0);
        @(negedge clk_i);
        chk(pad_oe_o & 16'h7FFF, 32'h0);
        chk(pad_analog_o & 16'h7FFF, 32'h7FFF);
        end_sim();
    end
endmodule : sppp_port_tb_top
bind sppp_port sppp_monitor mon (.*);
